// file: core/riet_event_timing.sv
// Interrupt event timing for radio sources 8 to 25 with flag registers
// Operation
// - Normal assessment ends after averaging, hold and two settling periods.
// - Idle result ends after averaging, hold and two settling periods.
// - Idle-mode busy result ends after averaging and two settling periods only.
// - Converter period is 17.7us or 16us by clock select bit.
// - Transmit-on: 122us from idle, 89us from receive.
// - Radio-off: 410us from transmit; 11us normal, 10us forced from receive.
// - Invalid transmit length written with a buffer free raises transmit length error at once.
// - Receive access error: third packet, overflow or underflow.
// - Transmit access error: third packet, overflow, underflow or empty.
// - Uncoded transmit completion: frame bit time plus 154us.
// - Coded transmit completion: body counted twice, plus 224us.
// - Receive completion: body bit time plus 5us, or doubled plus 315us.
// - Checksum error flag rises together with receive completion.
// - Request accepted flag rises once full frame is written.
// - Unlock flagged in transmit with amplifier on, receive with receiver on.
// - Masked causes stay latched and notify as soon as unmasked.
// - Symbol time is 10, 20, 5 or 2.5us by data rate.
// - Clearing assessment flag discards the assessment result.
// - Clearing a checksum flag erases that buffer's checksum result.
module riet_event_timing #(
  parameter int unsigned CYC_TX_IDLE =
    riet_pkg::ns2cyc(riet_pkg::T_TX_IDLE_NS),
  parameter int unsigned CYC_RX_IDLE =
    riet_pkg::ns2cyc(riet_pkg::T_RX_IDLE_NS),
  parameter int unsigned CYC_RX_TX = riet_pkg::ns2cyc(riet_pkg::T_RX_TX_NS),
  parameter int unsigned CYC_OFF_TX =
    riet_pkg::ns2cyc(riet_pkg::T_OFF_TX_NS),
  parameter int unsigned CYC_TX_WAKE =
    riet_pkg::ns2cyc(riet_pkg::T_TX_WAKE_NS),
  parameter int unsigned CYC_TX_WAKE_FEC =
    riet_pkg::ns2cyc(riet_pkg::T_TX_WAKE_FEC_NS),
  parameter int unsigned CYC_RX_PROC_FEC =
    riet_pkg::ns2cyc(riet_pkg::T_RX_PROC_FEC_NS)
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Register access from the serial host port
  input wire riet_pkg::riet_reg_t REG,
  output logic [7:0] REG_RDATA,
  // Radio commands and state
  input wire riet_pkg::riet_cmd_t CMD,
  output riet_pkg::riet_rf_t RF_STATE,
  // Modem setup
  input wire logic [1:0] DATA_RATE,
  input wire logic FEC_EN,
  // Channel assessment
  input wire riet_pkg::riet_cca_t CCA,
  output logic CCA_RESULT,
  // Packet buffers
  input wire riet_pkg::riet_tx_t TXP,
  input wire riet_pkg::riet_rx_t RXP,
  output logic [1:0] CRC_RESULT,
  // Synthesizer
  input wire logic PLL_UNLOCK,
  input wire logic PA_EN,
  input wire logic RX_EN,
  // Interrupt status
  output logic [31:0] INT_FLAGS,
  output logic INT_NOTIFY
);

  riet_pkg::riet_st_t st_ff;
  riet_pkg::riet_st_t nxt_st;
  logic [31:0] ev_v;
  logic [31:0] clr_v;
  logic rf_ld;
  logic tx_ld;
  logic rx_ld;
  logic [31:0] rf_val;
  logic [31:0] tx_val;
  logic [31:0] rx_val;
  logic rf_done;
  logic tx_done;
  logic rx_done;
  logic [9:0] conv_per;
  logic [16:0] cca_tgt;

  // ------------------------------------------------------------
  // Latency timers
  // ------------------------------------------------------------
  riet_timer u_rf_tmr (
    .clock(CLOCK),
    .rst_b(RST_B),
    .load(rf_ld),
    .load_val(rf_val),
    .done(rf_done)
  );

  riet_timer u_tx_tmr (
    .clock(CLOCK),
    .rst_b(RST_B),
    .load(tx_ld),
    .load_val(tx_val),
    .done(tx_done)
  );

  riet_timer u_rx_tmr (
    .clock(CLOCK),
    .rst_b(RST_B),
    .load(rx_ld),
    .load_val(rx_val),
    .done(rx_done)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic tb;
    logic rb;
    tb = 1'b0;
    rb = 1'b0;
    nxt_st = st_ff;
    ev_v = '0;
    clr_v = '0;
    rf_ld = 1'b0;
    tx_ld = 1'b0;
    rx_ld = 1'b0;
    rf_val = riet_pkg::CYC_ONE;
    tx_val = riet_pkg::CYC_ONE;
    rx_val = riet_pkg::CYC_ONE;
    conv_per = st_ff.conv[riet_pkg::CONV_SEL_BIT] ?
      riet_pkg::CYC_CONV_20 : riet_pkg::CYC_CONV_18;
    cca_tgt = {9'h0, st_ff.cca_avg} + riet_pkg::CCA_SETTLE;
    if (!(st_ff.cca_idle && st_ff.cca_busy)) begin
      cca_tgt = 17'(cca_tgt + {1'b0, st_ff.hold});
    end

    // Register writes; status bytes clear on ones
    if (REG.wr) begin
      unique case (REG.addr)
        riet_pkg::ADDR_CONV: nxt_st.conv = REG.wdata;
        riet_pkg::ADDR_HOLD_LO: nxt_st.hold[7:0] = REG.wdata;
        riet_pkg::ADDR_HOLD_HI: nxt_st.hold[15:8] = REG.wdata;
        default: begin
          for (int b = 0; b < 4; b++) begin
            if (REG.addr == riet_pkg::ADDR_STAT0 + 8'(b)) begin
              clr_v[8*b +: 8] = REG.wdata;
            end
            if (REG.addr == riet_pkg::ADDR_MASK0 + 8'(b)) begin
              nxt_st.mask[8*b +: 8] = REG.wdata;
            end
          end
        end
      endcase
    end

    // Register reads; unmapped offsets read zero
    if (REG.rd) begin
      unique case (REG.addr)
        riet_pkg::ADDR_CONV: nxt_st.rdata = st_ff.conv;
        riet_pkg::ADDR_HOLD_LO: nxt_st.rdata = st_ff.hold[7:0];
        riet_pkg::ADDR_HOLD_HI: nxt_st.rdata = st_ff.hold[15:8];
        default: begin
          nxt_st.rdata = 8'h00;
          for (int b = 0; b < 4; b++) begin
            if (REG.addr == riet_pkg::ADDR_STAT0 + 8'(b)) begin
              nxt_st.rdata = st_ff.flags[8*b +: 8];
            end
            if (REG.addr == riet_pkg::ADDR_MASK0 + 8'(b)) begin
              nxt_st.rdata = st_ff.mask[8*b +: 8];
            end
          end
        end
      endcase
    end

    // Radio state transitions; force beats normal off beats receive
    if (CMD.force_off || CMD.off) begin
      rf_ld = 1'b1;
      nxt_st.pend = riet_pkg::RF_IDLE;
      unique case (st_ff.rf)
        riet_pkg::RF_TX: rf_val = CYC_OFF_TX;
        riet_pkg::RF_RX: rf_val = CMD.force_off ?
          riet_pkg::CYC_FOFF_RX : riet_pkg::CYC_OFF_RX;
        default: rf_val = riet_pkg::CYC_ONE;
      endcase
    end else if (CMD.rx_on) begin
      rf_ld = 1'b1;
      nxt_st.pend = riet_pkg::RF_RX;
      unique case (st_ff.rf)
        riet_pkg::RF_IDLE: rf_val = CYC_RX_IDLE;
        riet_pkg::RF_TX: rf_val = CYC_RX_TX;
        default: rf_val = riet_pkg::CYC_ONE;
      endcase
    end else if (CMD.tx_on) begin
      rf_ld = 1'b1;
      nxt_st.pend = riet_pkg::RF_TX;
      unique case (st_ff.rf)
        riet_pkg::RF_IDLE: rf_val = CYC_TX_IDLE;
        riet_pkg::RF_RX: rf_val = riet_pkg::CYC_TX_RX;
        default: rf_val = riet_pkg::CYC_ONE;
      endcase
    end
    if (rf_done) begin
      nxt_st.rf = st_ff.pend;
      ev_v[riet_pkg::INT_RF] = 1'b1;
    end

    // Channel assessment counted in converter periods
    if (CCA.start) begin
      nxt_st.cca_on = 1'b1;
      nxt_st.cca_idle = CCA.idle_mode;
      nxt_st.cca_avg = CCA.avg;
      nxt_st.cca_busy = 1'b0;
      nxt_st.cca_smp = '0;
      nxt_st.cca_div = conv_per - 10'h1;
    end else if (st_ff.cca_on) begin
      if (CCA.busy) begin
        nxt_st.cca_busy = 1'b1;
      end
      if (st_ff.cca_div == 10'h0) begin
        nxt_st.cca_div = conv_per - 10'h1;
        nxt_st.cca_smp = st_ff.cca_smp + 17'h1;
      end else begin
        nxt_st.cca_div = st_ff.cca_div - 10'h1;
      end
      if (st_ff.cca_smp >= cca_tgt) begin
        nxt_st.cca_on = 1'b0;
        nxt_st.cca_res = st_ff.cca_busy;
        ev_v[riet_pkg::INT_CCA] = 1'b1;
      end
    end

    // Transmit buffer filling; the first free buffer takes the frame
    if (TXP.start) begin
      if (&st_ff.tx_pend) begin
        ev_v[riet_pkg::INT_TX_ACC] = 1'b1;
      end else if (TXP.len == 12'h0 || TXP.len > riet_pkg::MAX_LEN) begin
        ev_v[riet_pkg::INT_TX_LEN] = 1'b1;
      end else begin
        nxt_st.wr_act = 1'b1;
        nxt_st.wr_buf = st_ff.tx_pend[0];
        nxt_st.wr_cnt = '0;
        nxt_st.tx_len[st_ff.tx_pend[0]] = TXP.len;
      end
    end else if (TXP.wr) begin
      if (!st_ff.wr_act) begin
        ev_v[riet_pkg::INT_TX_ACC] = 1'b1;
      end else begin
        nxt_st.wr_cnt = 12'(st_ff.wr_cnt + 12'h1);
        if (nxt_st.wr_cnt == st_ff.tx_len[st_ff.wr_buf]) begin
          nxt_st.wr_act = 1'b0;
          nxt_st.tx_pend[st_ff.wr_buf] = 1'b1;
          ev_v[riet_pkg::INT_TX_REQ0 + int'(st_ff.wr_buf)] = 1'b1;
        end
      end
    end

    // Transmission from buffer tx_next if pending, else from the other buffer
    if (CMD.tx_on) begin
      if (st_ff.tx_pend == 2'h0) begin
        ev_v[riet_pkg::INT_TX_ACC] = 1'b1;
      end else begin
        tb = st_ff.tx_pend[st_ff.tx_next] ? st_ff.tx_next : !st_ff.tx_next;
        nxt_st.tx_cur = tb;
        tx_ld = 1'b1;
        tx_val = riet_pkg::frame_cyc(TXP.pre, st_ff.tx_len[tb], FEC_EN,
          DATA_RATE) + (FEC_EN ? CYC_TX_WAKE_FEC : CYC_TX_WAKE);
      end
    end
    if (TXP.underrun) begin
      ev_v[riet_pkg::INT_TX_ACC] = 1'b1;
    end
    if (tx_done) begin
      ev_v[riet_pkg::INT_TX_DONE0 + int'(st_ff.tx_cur)] = 1'b1;
      nxt_st.tx_pend[st_ff.tx_cur] = 1'b0;
      nxt_st.tx_next = !st_ff.tx_cur;
    end

    // Reception into the buffers
    nxt_st.rx_full = st_ff.rx_full & ~RXP.rd_done;
    if (RXP.sfd) begin
      if (&st_ff.rx_full) begin
        ev_v[riet_pkg::INT_RX_ACC] = 1'b1;
      end else begin
        rb = st_ff.rx_full[st_ff.rx_wptr] ? !st_ff.rx_wptr : st_ff.rx_wptr;
        nxt_st.rx_cur = rb;
        rx_ld = 1'b1;
        rx_val = riet_pkg::frame_cyc(8'h00, RXP.len, FEC_EN, DATA_RATE) +
          (FEC_EN ? CYC_RX_PROC_FEC : riet_pkg::CYC_RX_PROC);
      end
    end
    if (RXP.overrun || RXP.underrun) begin
      ev_v[riet_pkg::INT_RX_ACC] = 1'b1;
    end
    if (rx_done) begin
      ev_v[riet_pkg::INT_RX_DONE0 + int'(st_ff.rx_cur)] = 1'b1;
      nxt_st.rx_full[st_ff.rx_cur] = 1'b1;
      nxt_st.rx_wptr = !st_ff.rx_cur;
      if (RXP.crc_bad) begin
        ev_v[riet_pkg::INT_CRC0 + int'(st_ff.rx_cur)] = 1'b1;
        nxt_st.crc_res[st_ff.rx_cur] = 1'b1;
      end
    end

    // Synthesizer lock loss only counts while the path is live
    if (PLL_UNLOCK && ((st_ff.rf == riet_pkg::RF_TX && PA_EN) ||
        (st_ff.rf == riet_pkg::RF_RX && RX_EN))) begin
      ev_v[riet_pkg::INT_UNLOCK] = 1'b1;
    end

    // Sticky flags; a same-cycle event beats the clear
    nxt_st.flags = ((st_ff.flags & ~clr_v) | ev_v) &
      riet_pkg::INT_USED;
    if (clr_v[riet_pkg::INT_CCA] && !ev_v[riet_pkg::INT_CCA]) begin
      nxt_st.cca_res = 1'b0;
    end
    for (int b = 0; b < 2; b++) begin
      if (clr_v[riet_pkg::INT_CRC0 + b] && !ev_v[riet_pkg::INT_CRC0 + b]) begin
        nxt_st.crc_res[b] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= '0;
      st_ff.mask <= riet_pkg::MASK_RST;
      st_ff.conv <= riet_pkg::CONV_RST;
      st_ff.hold <= riet_pkg::HOLD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign REG_RDATA = st_ff.rdata;
  assign RF_STATE = st_ff.rf;
  assign CCA_RESULT = st_ff.cca_res;
  assign CRC_RESULT = st_ff.crc_res;
  assign INT_FLAGS = st_ff.flags;
  // Mask gates only the notification, never the latched cause
  assign INT_NOTIFY = |(st_ff.flags & st_ff.mask);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  AST_STICKY_HOLD: assert property (
    &(~$past(st_ff.flags) | st_ff.flags | $past(clr_v)))
    else $error("Flag dropped without a clear");

  AST_UNMASK_NOTIFY: assert property (
    st_ff.flags[riet_pkg::INT_UNLOCK] &&
    $rose(st_ff.mask[riet_pkg::INT_UNLOCK])
    |-> INT_NOTIFY)
    else $error("Latched cause not notified on unmask");

  AST_CCA_DISCARD: assert property (
    clr_v[riet_pkg::INT_CCA] && !ev_v[riet_pkg::INT_CCA] |=> !CCA_RESULT)
    else $error("Assessment result kept after clear");

  AST_CRC_ERASE: assert property (
    clr_v[riet_pkg::INT_CRC0] && !ev_v[riet_pkg::INT_CRC0]
    |=> !CRC_RESULT[0])
    else $error("Checksum result kept after clear");

  AST_TX_LEN_ERR: assert property (
    TXP.start && st_ff.tx_pend != 2'h3 && TXP.len == 12'h0
    |=> INT_FLAGS[riet_pkg::INT_TX_LEN])
    else $error("Zero length not flagged");

  AST_RX_THIRD: assert property (
    RXP.sfd && st_ff.rx_full == 2'h3 |=> INT_FLAGS[riet_pkg::INT_RX_ACC])
    else $error("Third receive packet not flagged");

  AST_TX_EMPTY: assert property (
    CMD.tx_on && st_ff.tx_pend == 2'h0 |=> INT_FLAGS[riet_pkg::INT_TX_ACC])
    else $error("Transmit from empty buffers not flagged");

  AST_TX_ACCEPT: assert property (
    TXP.wr && !TXP.start && st_ff.wr_act &&
    12'(st_ff.wr_cnt + 12'h1) == st_ff.tx_len[st_ff.wr_buf]
    |=> INT_FLAGS[riet_pkg::INT_TX_REQ0] ||
        INT_FLAGS[riet_pkg::INT_TX_REQ0 + 1])
    else $error("Full frame not accepted");

  AST_UNLOCK_TX: assert property (
    PLL_UNLOCK && PA_EN && RF_STATE == riet_pkg::RF_TX
    |=> INT_FLAGS[riet_pkg::INT_UNLOCK])
    else $error("Unlock in transmit not flagged");

  AST_CRC_WITH_RX: assert property (
    $rose(CRC_RESULT[0]) |-> $past(rx_done) && !$past(st_ff.rx_cur))
    else $error("Checksum error apart from receive completion");

  COV_CCA_DONE: cover property (ev_v[riet_pkg::INT_CCA]);
  COV_TX_DONE: cover property (tx_done);
  COV_RX_CRC: cover property (rx_done && RXP.crc_bad);

endmodule : riet_event_timing

// file: common/riet_pkg.sv
// Constants and types of the radio interrupt event timing block
package riet_pkg;

  // ------------------------------------------------------------
  // Clock and time conversion
  // ------------------------------------------------------------
  localparam int CLK_NS = 25;

  // Least times round up, never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc

  // ------------------------------------------------------------
  // Register offsets, fields and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV = 8'h08;
  localparam logic [7:0] ADDR_HOLD_LO = 8'h17;
  localparam logic [7:0] ADDR_HOLD_HI = 8'h18;
  localparam logic [7:0] ADDR_STAT0 = 8'h24;
  localparam logic [7:0] ADDR_MASK0 = 8'h28;
  localparam int CONV_SEL_BIT = 4;
  localparam logic [7:0] CONV_RST = 8'h00;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // ------------------------------------------------------------
  // Interrupt bit positions
  // ------------------------------------------------------------
  localparam int INT_CCA = 8;
  localparam int INT_RF = 10;
  localparam int INT_TX_LEN = 13;
  localparam int INT_RX_ACC = 14;
  localparam int INT_TX_ACC = 15;
  localparam int INT_TX_DONE0 = 16;
  localparam int INT_RX_DONE0 = 18;
  localparam int INT_CRC0 = 20;
  localparam int INT_TX_REQ0 = 22;
  localparam int INT_UNLOCK = 25;
  localparam logic [31:0] INT_USED = 32'h03ff_ff00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int T_CONV_18_NS = 17700;
  localparam int T_CONV_20_NS = 16000;
  localparam logic [9:0] CYC_CONV_18 = 10'(ns2cyc(T_CONV_18_NS));
  localparam logic [9:0] CYC_CONV_20 = 10'(ns2cyc(T_CONV_20_NS));
  localparam logic [16:0] CCA_SETTLE = 17'h2;
  localparam int T_TX_IDLE_NS = 122000;
  localparam int T_TX_RX_NS = 89000;
  localparam int T_RX_IDLE_NS = 136000;
  localparam int T_RX_TX_NS = 142000;
  localparam int T_OFF_TX_NS = 410000;
  localparam int T_OFF_RX_NS = 11000;
  localparam int T_FOFF_RX_NS = 10000;
  localparam int T_TX_WAKE_NS = 154000;
  localparam int T_TX_WAKE_FEC_NS = 224000;
  localparam int T_RX_PROC_NS = 5000;
  localparam int T_RX_PROC_FEC_NS = 315000;
  localparam logic [31:0] CYC_TX_RX = 32'(ns2cyc(T_TX_RX_NS));
  localparam logic [31:0] CYC_OFF_RX = 32'(ns2cyc(T_OFF_RX_NS));
  localparam logic [31:0] CYC_FOFF_RX = 32'(ns2cyc(T_FOFF_RX_NS));
  localparam logic [31:0] CYC_RX_PROC = 32'(ns2cyc(T_RX_PROC_NS));
  localparam logic [31:0] CYC_ONE = 32'h1;
  localparam logic [1:0] RATE_100 = 2'h0;
  localparam logic [1:0] RATE_50 = 2'h1;
  localparam logic [1:0] RATE_200 = 2'h2;
  localparam logic [1:0] RATE_400 = 2'h3;
  localparam logic [31:0] CYC_SYM_100 = 32'(ns2cyc(10000));
  localparam logic [31:0] CYC_SYM_50 = 32'(ns2cyc(20000));
  localparam logic [31:0] CYC_SYM_200 = 32'(ns2cyc(5000));
  localparam logic [31:0] CYC_SYM_400 = 32'(ns2cyc(2500));
  localparam logic [31:0] BYTE_BITS = 32'h8;
  localparam logic [11:0] MAX_LEN = 12'h7ff;

  // Symbol time scales with the data rate
  function automatic logic [31:0] sym_cyc(input logic [1:0] rate);
    unique case (rate)
      RATE_50: return CYC_SYM_50;
      RATE_200: return CYC_SYM_200;
      RATE_400: return CYC_SYM_400;
      default: return CYC_SYM_100;
    endcase
  endfunction : sym_cyc

  // Bit time of a frame; coded bytes count twice with error correction
  function automatic logic [31:0] frame_cyc(input logic [7:0] pre,
      input logic [11:0] body, input logic fec, input logic [1:0] rate);
    logic [31:0] nbytes;
    nbytes = {24'h0, pre} + (fec ? {19'h0, body, 1'b0} : {20'h0, body});
    return 32'(nbytes * BYTE_BITS * sym_cyc(rate));
  endfunction : frame_cyc

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {RF_IDLE, RF_RX, RF_TX} riet_rf_t;
  typedef struct packed {
    logic [7:0] addr; logic [7:0] wdata; logic wr; logic rd;
  } riet_reg_t;
  typedef struct packed {
    logic tx_on; logic rx_on; logic off; logic force_off;
  } riet_cmd_t;
  typedef struct packed {
    logic start; logic idle_mode; logic [7:0] avg; logic busy;
  } riet_cca_t;
  typedef struct packed {
    logic start; logic [11:0] len; logic wr; logic [7:0] pre;
    logic underrun;
  } riet_tx_t;
  typedef struct packed {
    logic sfd; logic [11:0] len; logic crc_bad; logic overrun;
    logic underrun; logic [1:0] rd_done;
  } riet_rx_t;
  typedef struct packed {
    logic [7:0] conv; logic [15:0] hold; logic [31:0] flags;
    logic [31:0] mask; logic [7:0] rdata; riet_rf_t rf; riet_rf_t pend;
    logic cca_on; logic cca_idle; logic cca_busy; logic cca_res;
    logic [7:0] cca_avg; logic [16:0] cca_smp; logic [9:0] cca_div;
    logic [1:0] tx_pend; logic tx_next; logic tx_cur; logic wr_act;
    logic wr_buf; logic [11:0] wr_cnt; logic [1:0][11:0] tx_len;
    logic [1:0] rx_full; logic rx_wptr; logic rx_cur;
    logic [1:0] crc_res;
  } riet_st_t;
  typedef struct packed {
    logic busy; logic [31:0] cnt; logic done;
  } riet_tmr_t;

endpackage : riet_pkg

// file: core/riet_timer.sv
// One-shot latency timer that pulses when a loaded count expires
module riet_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [31:0] load_val,
  // Expiry
  output logic done
);

  riet_pkg::riet_tmr_t st_ff;
  riet_pkg::riet_tmr_t nxt_st;

  // ------------------------------------------------------------
  // Count down
  // ------------------------------------------------------------
  // A new load restarts the count, so a later event supersedes
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (load) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = load_val;
    end else if (st_ff.busy) begin
      if (st_ff.cnt <= riet_pkg::CYC_ONE) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - riet_pkg::CYC_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

endmodule : riet_timer

// file: verification/riet_host.sv
// Host model driving the serial register port of the event block
module riet_host (
  // Clock
  input wire logic clock,
  // Register port
  input wire logic [7:0] rdata,
  output riet_pkg::riet_reg_t host_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_reg = '0;
  // One-cycle strobes, changed only at the falling edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    host_reg = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clock);
    host_reg = '0;
  endtask : write_reg
  // Data is registered at the edge that takes the strobe and is sampled a cycle later
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    host_reg = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clock);
    host_reg = '0;
    @(negedge clock);
    d = rdata;
  endtask : read_reg
endmodule : riet_host

// file: verification/radio_interrupt_event_timing_tb.sv
// Self-checking bench of the radio interrupt event timing block
module radio_interrupt_event_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_b = 0, pa_en = 0, rx_en = 0, unlock = 0, fec = 0;
  logic [1:0] rate = 2'h3, crc_res, rf;
  logic [7:0] rdata, rd;
  logic [31:0] flags;
  logic notify, cca_res;
  riet_pkg::riet_reg_t host_reg;
  riet_pkg::riet_cmd_t cmd = '0;
  riet_pkg::riet_cca_t cca = '0;
  riet_pkg::riet_tx_t txp = '0;
  riet_pkg::riet_rx_t rxp = '0;
  int fails = 0, n_checks = 0, t, len;
  initial forever #12.5 clock = ~clock;
  riet_host host (.clock(clock), .rdata(rdata), .host_reg(host_reg));
  // Five latencies shortened to 20; the rest keep their true counts
  riet_event_timing #(.CYC_TX_IDLE(20), .CYC_RX_IDLE(20), .CYC_OFF_TX(20),
    .CYC_TX_WAKE(20), .CYC_RX_PROC_FEC(20)) dut (.CLOCK(clock),
    .RST_B(rst_b),
    .REG(host_reg), .REG_RDATA(rdata), .CMD(cmd), .RF_STATE(rf),
    .DATA_RATE(rate), .FEC_EN(fec), .CCA(cca), .CCA_RESULT(cca_res),
    .TXP(txp), .RXP(rxp), .CRC_RESULT(crc_res), .PLL_UNLOCK(unlock),
    .PA_EN(pa_en), .RX_EN(rx_en), .INT_FLAGS(flags), .INT_NOTIFY(notify));
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Timer loaded with n raises its flag n + 1 edges after the request
  task automatic at_lat(input string nm, input int bit_i, input int n);
    tick(n);
    chk(nm, 32'(flags[bit_i]), 0);
    tick(1);
    chk(nm, 32'(flags[bit_i]), 1);
  endtask : at_lat
  // Symbol cycles per rate code: 10, 20, 5 and 2.5us
  function automatic int sym_c(input logic [1:0] r);
    return (r == 2'h0) ? 400 : (r == 2'h1) ? 800 : (r == 2'h2) ? 200 : 100;
  endfunction : sym_c
  function automatic int tx_cyc(input int l);
    return l * 8 * sym_c(rate) + 20; // wake shortened to 20
  endfunction : tx_cyc
  // Coded bytes count twice; processing is 5us plain, 20 cycles coded
  function automatic int rx_cyc(input int l, input logic f);
    return l * (f ? 2 : 1) * 8 * sym_c(rate) + (f ? 20 : 200);
  endfunction : rx_cyc
  task automatic give_verdict;
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h9062));
    rate = 2'h2 | 2'($urandom % 2);
    tick(8);
    rst_b = 1;
    host.read_reg(8'h18, rd);
    chk("hold_hi", 32'(rd), 0);
    host.read_reg(8'h40, rd);
    chk("unmapped", 32'(rd), 0);
    t = $urandom;
    host.write_reg(8'h17, t[7:0]);
    host.read_reg(8'h17, rd);
    chk("hold_lo", 32'(rd), 32'(t[7:0]));
    // Zero length is refused at once
    tick(1); txp.start = 1; txp.len = 12'h000; tick(1); txp.start = 0;
    tick(1); chk("len_err", 32'(flags[13]), 1);
    // Whole frame is loaded before transmit-on
    len = 1 + ($urandom % 3);
    txp.start = 1; txp.len = 12'(len); tick(1); txp.start = 0;
    txp.wr = 1; tick(len); txp.wr = 0;
    tick(1); chk("tx_req", 32'(flags[22]), 1);
    cmd.tx_on = 1; tick(1); cmd.tx_on = 0;
    tick(21); chk("rf_tx", 32'(flags[10]), 1);
    chk("rf_state", 32'(rf), 32'(riet_pkg::RF_TX));
    at_lat("tx_done", 16, tx_cyc(len) - 21);
    pa_en = 1; unlock = 1; tick(1); unlock = 0;
    tick(1); chk("unlock", 32'(flags[25]), 1);
    chk("masked", 32'(notify), 0);
    host.write_reg(8'h2b, 8'h02);
    tick(1); chk("notify", 32'(notify), 1);
    host.write_reg(8'h27, 8'h02);
    tick(1); chk("clear", 32'(flags[25]), 0);
    chk("sticky", 32'(flags[22]), 1);
    cmd.tx_on = 1; tick(1); cmd.tx_on = 0;
    tick(1); chk("tx_empty", 32'(flags[15]), 1);
    host.write_reg(8'h25, 8'h04);
    cmd.off = 1; tick(1); cmd.off = 0;
    tick(22); chk("off", 32'(rf), 32'(riet_pkg::RF_IDLE));
    // Receive-on from idle, then lock loss with the receiver live
    cmd.rx_on = 1; tick(1); cmd.rx_on = 0;
    tick(21); chk("rf_rx", 32'(rf), 32'(riet_pkg::RF_RX));
    rx_en = 1; unlock = 1; tick(1); unlock = 0;
    tick(1); chk("unlock_rx", 32'(flags[25]), 1);
    fec = 1'($urandom % 2);
    rxp.sfd = 1; rxp.len = 12'h001; rxp.crc_bad = 1; tick(1); rxp.sfd = 0;
    at_lat("rx_done", 18, rx_cyc(1, fec));
    chk("crc_flag", 32'(flags[20]), 1);
    chk("crc_res", 32'(crc_res[0]), 1);
    host.write_reg(8'h26, 8'h10);
    tick(1); chk("crc_erase", 32'(crc_res[0]), 0);
    // Busy in idle mode drops the hold count: 3 samples of 640 cycles
    host.write_reg(8'h08, 8'h10);
    host.write_reg(8'h17, 8'h01);
    cca = '{start: 1'b1, idle_mode: 1'b1, avg: 8'h01, busy: 1'b1};
    tick(1); cca.start = 0; t = 0;
    while (flags[8] !== 1'b1 && t < 2500) begin
      tick(1); t++;
    end
    chk("cca_time", 32'(t >= 1920 && t <= 1924), 1);
    chk("cca_res", 32'(cca_res), 1);
    host.write_reg(8'h25, 8'h01);
    tick(1); chk("cca_erase", 32'(cca_res), 0);
    give_verdict();
  end
endmodule : radio_interrupt_event_timing_tb
